// ### verilog/flash_erase_cfg.svh
// constants of the flash erase sequencer: geometry, encodings, timing, reset values
`ifndef FLASH_ERASE_CFG_SVH
`define FLASH_ERASE_CFG_SVH
// ---------------------------------------------
// geometry
// ---------------------------------------------
`define FEC_ADDR_W          20
`define FEC_BANK_W          4
`define FEC_SEG_W           8
`define FEC_MAIN_SEG_BYTES  20'h00200
`define FEC_INFO_SEG_BYTES  20'h00080
`define FEC_INFO_SEGS       20'h00004
`define FEC_BOOT_SEG_BYTES  20'h00200
`define FEC_BOOT_SEGS       20'h00004
`define FEC_INFO_SEG_A_IDX  8'h00
`define FEC_BANK_BYTES      20'h10000
`define FEC_NUM_BANKS       4
`define FEC_MAIN_BASE       20'h04000
`define FEC_INFO_BASE       20'h01800
`define FEC_BOOT_BASE       20'h01000
// ---------------------------------------------
// erase mode encodings {multi_erase_select, erase}
// ---------------------------------------------
`define FEC_MODE_NONE       2'h0
`define FEC_MODE_SEG        2'h1
`define FEC_MODE_BANK       2'h2
`define FEC_MODE_MASS       2'h3
// ---------------------------------------------
// timing and reset values
// ---------------------------------------------
`define FEC_CLK_MHZ         25
`define FEC_SEG_ERASE_US    25000
`define FEC_MASS_ERASE_US   25000
`define FEC_RST_GEN_LOCK    1'h1
`define FEC_RST_SEG_A_LOCK  1'h1
`define FEC_RST_INFO_LOCK   1'h1
`endif

// ### verilog/flash_erase_pkg.sv
// types shared by the flash erase sequencer and its address decoder
`include "flash_erase_cfg.svh"
package flash_erase_pkg;
    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_ERASE = 1'b1
    } erase_state_e;

    typedef enum logic [1:0] {
        RG_NONE = 2'h0,
        RG_MAIN = 2'h1,
        RG_INFO = 2'h2,
        RG_BOOT = 2'h3
    } region_e;

    typedef enum logic [1:0] {
        EK_NONE = `FEC_MODE_NONE,
        EK_SEG  = `FEC_MODE_SEG,
        EK_BANK = `FEC_MODE_BANK,
        EK_MASS = `FEC_MODE_MASS
    } erase_kind_e;

    typedef struct packed {
        region_e                region;
        logic [`FEC_BANK_W-1:0] bank;
        logic [`FEC_SEG_W-1:0]  seg;
    } region_info_s;

    typedef struct packed {
        logic                   req;
        logic                   we;
        logic [`FEC_ADDR_W-1:0] addr;
    } bus_req_s;

    typedef struct packed {
        logic mode_wr;
        logic multi_erase_select;
        logic erase_select;
        logic ctl3_wr;
        logic general_lock;
        logic info_seg_a_lock;
        logic ctl4_wr;
        logic info_region_lock;
    } ctl_wr_s;

    typedef struct packed {
        erase_state_e st;
        logic [31:0]  cnt;
        logic [1:0]   mode;
        logic         lock_gen;
        logic         lock_a;
        logic         lock_info;
        logic         acc_viol;
        logic         stall;
        erase_kind_e  kind;
        region_info_s tgt;
        logic [15:0]  mask;
        logic         apply;
        logic         prog_valid;
        logic [15:0]  prog_word;
    } erase_ctl_s;
endpackage : flash_erase_pkg

// ### verilog/flash_region_decode.sv
// address to region, bank and segment decoder for the flash array
`timescale 1ns/10ps
`include "flash_erase_cfg.svh"
module flash_region_decode import flash_erase_pkg::*; #(
    parameter int unsigned          NUM_BANKS  = `FEC_NUM_BANKS,
    parameter logic [`FEC_ADDR_W-1:0] BANK_BYTES = `FEC_BANK_BYTES,
    parameter logic [`FEC_ADDR_W-1:0] MAIN_BASE  = `FEC_MAIN_BASE,
    parameter logic [`FEC_ADDR_W-1:0] INFO_BASE  = `FEC_INFO_BASE,
    parameter logic [`FEC_ADDR_W-1:0] BOOT_BASE  = `FEC_BOOT_BASE
) (
    input  wire logic [`FEC_ADDR_W-1:0] i_addr,
    output region_info_s                o_hit
);
    localparam logic [`FEC_ADDR_W-1:0] INFO_SPAN = 20'(`FEC_INFO_SEGS * `FEC_INFO_SEG_BYTES);
    localparam logic [`FEC_ADDR_W-1:0] BOOT_SPAN = 20'(`FEC_BOOT_SEGS * `FEC_BOOT_SEG_BYTES);
    localparam logic [`FEC_ADDR_W:0]   MAIN_SPAN = 21'(NUM_BANKS * BANK_BYTES);

    logic [`FEC_ADDR_W-1:0] main_off;
    logic [`FEC_ADDR_W-1:0] info_off;
    logic [`FEC_ADDR_W-1:0] boot_off;

    always_comb begin
        main_off = i_addr - MAIN_BASE;
        info_off = i_addr - INFO_BASE;
        boot_off = i_addr - BOOT_BASE;
        o_hit    = '0;
        if (i_addr >= INFO_BASE && info_off < INFO_SPAN) begin
            o_hit.region = RG_INFO;
            o_hit.seg    = 8'(info_off / `FEC_INFO_SEG_BYTES);
        end else if (i_addr >= BOOT_BASE && boot_off < BOOT_SPAN) begin
            o_hit.region = RG_BOOT;
            o_hit.seg    = 8'(boot_off / `FEC_BOOT_SEG_BYTES);
        end else if (i_addr >= MAIN_BASE && {1'b0, main_off} < MAIN_SPAN) begin
            o_hit.region = RG_MAIN;
            o_hit.bank   = 4'(main_off / BANK_BYTES);
            o_hit.seg    = 8'((main_off % BANK_BYTES) / `FEC_MAIN_SEG_BYTES);
        end
    end
endmodule : flash_region_decode

// ### verilog/flash_erase_controller.sv
// erase sequencer of the flash controller: locks, erase modes, busy timing, read gating
`timescale 1ns/10ps
`include "flash_erase_cfg.svh"
module flash_erase_controller import flash_erase_pkg::*; #(
    parameter int unsigned            NUM_BANKS     = `FEC_NUM_BANKS,
    parameter logic [`FEC_ADDR_W-1:0] BANK_BYTES    = `FEC_BANK_BYTES,
    parameter logic [`FEC_ADDR_W-1:0] MAIN_BASE     = `FEC_MAIN_BASE,
    parameter logic [`FEC_ADDR_W-1:0] INFO_BASE     = `FEC_INFO_BASE,
    parameter logic [`FEC_ADDR_W-1:0] BOOT_BASE     = `FEC_BOOT_BASE,
    parameter int unsigned            SEG_ERASE_US  = `FEC_SEG_ERASE_US,
    parameter int unsigned            MASS_ERASE_US = `FEC_MASS_ERASE_US
) (
    input  wire logic           i_clk_sys,
    input  wire logic           i_nrst,
    input  wire bus_req_s       i_bus,
    input  wire logic           i_exec_from_flash,
    input  wire ctl_wr_s        i_ctl,
    input  wire logic           i_acc_viol_clr,
    input  wire logic           i_prog_req,
    input  wire logic [15:0]    i_prog_old,
    input  wire logic [15:0]    i_prog_new,
    output logic                o_busy,
    output logic [1:0]          o_erase_mode,
    output logic                o_general_lock,
    output logic                o_info_seg_a_lock,
    output logic                o_info_region_lock,
    output logic                o_access_violation_flag,
    output logic                o_cpu_stall,
    output logic                o_read_mode,
    output logic                o_timing_gen_on,
    output logic                o_hv_gen_on,
    output logic                o_read_ok,
    output logic                o_write_ok,
    output logic                o_erase_apply,
    output erase_kind_e         o_erase_kind,
    output region_info_s        o_erase_target,
    output logic [NUM_BANKS-1:0] o_erase_bank_mask,
    output logic                o_prog_valid,
    output logic [15:0]         o_prog_word
);
    // ---------------------------------------------
    // timing
    // ---------------------------------------------
    // one timer for every device size: mass erase time does not scale
    localparam int unsigned SEG_RAW  = SEG_ERASE_US * `FEC_CLK_MHZ;
    localparam int unsigned MASS_RAW = MASS_ERASE_US * `FEC_CLK_MHZ;
    localparam logic [31:0] SEG_CYC  = (SEG_RAW < 1) ? 32'h1 : 32'(SEG_RAW);
    localparam logic [31:0] MASS_CYC = (MASS_RAW < 1) ? 32'h1 : 32'(MASS_RAW);

    localparam erase_ctl_s S_RST = '{
        st:         ST_IDLE,
        cnt:        32'h0,
        mode:       `FEC_MODE_NONE,
        lock_gen:   `FEC_RST_GEN_LOCK,
        lock_a:     `FEC_RST_SEG_A_LOCK,
        lock_info:  `FEC_RST_INFO_LOCK,
        acc_viol:   1'b0,
        stall:      1'b0,
        kind:       EK_NONE,
        tgt:        '0,
        mask:       16'h0,
        apply:      1'b0,
        prog_valid: 1'b0,
        prog_word:  16'h0
    };

    erase_ctl_s   s_r;
    erase_ctl_s   s_nxt;
    region_info_s hit;
    erase_kind_e  sel_kind;
    logic         busy;
    logic         flash_wr;
    logic         flash_rd;
    logic         is_seg_a;
    logic         wr_locked;
    logic         erase_locked;
    logic         start;
    logic         conflict;
    logic [15:0]  start_mask;

    flash_region_decode #(
        .NUM_BANKS  (NUM_BANKS),
        .BANK_BYTES (BANK_BYTES),
        .MAIN_BASE  (MAIN_BASE),
        .INFO_BASE  (INFO_BASE),
        .BOOT_BASE  (BOOT_BASE)
    ) u_decode (
        .i_addr (i_bus.addr),
        .o_hit  (hit)
    );

    // ---------------------------------------------
    // access classification
    // ---------------------------------------------
    assign busy     = (s_r.st == ST_ERASE);
    assign sel_kind = erase_kind_e'(s_r.mode);
    assign flash_wr = i_bus.req && i_bus.we && (hit.region != RG_NONE);
    assign flash_rd = i_bus.req && !i_bus.we && (hit.region != RG_NONE);
    assign is_seg_a = (hit.region == RG_INFO) && (hit.seg == `FEC_INFO_SEG_A_IDX);

    // segment A open only when its own lock is clear
    assign wr_locked = s_r.lock_gen
                     || ((hit.region == RG_INFO) && s_r.lock_info)
                     || (is_seg_a && s_r.lock_a);

    always_comb begin
        erase_locked = wr_locked;
        // lock A also shields every info segment from segment erase
        if (hit.region == RG_INFO && sel_kind == EK_SEG && s_r.lock_a) begin
            erase_locked = 1'b1;
        end
        // bank and mass erase only aim at main memory
        if ((sel_kind == EK_BANK || sel_kind == EK_MASS) && hit.region != RG_MAIN) begin
            erase_locked = 1'b1;
        end
    end

    assign start = !busy && flash_wr && (sel_kind != EK_NONE) && !erase_locked;

    // ---------------------------------------------
    // banks touched by the starting erase
    // ---------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_mask
            if (g < NUM_BANKS) begin : g_real
                assign start_mask[g] = (sel_kind == EK_MASS)
                                     || ((sel_kind == EK_BANK) && (hit.bank == 4'(g)));
            end else begin : g_none
                assign start_mask[g] = 1'b0;
            end
        end
    endgenerate

    // a single bank holds all flash, so nothing is readable mid-erase
    always_comb begin
        conflict = 1'b0;
        if (busy && hit.region != RG_NONE) begin
            if (NUM_BANKS == 1) begin
                conflict = 1'b1;
            end else if (s_r.tgt.region == RG_MAIN) begin
                conflict = (hit.region == RG_MAIN)
                        && ((s_r.kind == EK_MASS) || (hit.bank == s_r.tgt.bank));
            end else begin
                conflict = (hit.region == s_r.tgt.region);
            end
        end
    end

    // ---------------------------------------------
    // next state
    // ---------------------------------------------
    always_comb begin
        s_nxt            = s_r;
        s_nxt.apply      = 1'b0;
        s_nxt.prog_valid = 1'b0;
        if (i_ctl.ctl3_wr) begin
            s_nxt.lock_gen = i_ctl.general_lock;
            if (i_ctl.info_seg_a_lock) begin
                s_nxt.lock_a = !s_r.lock_a;
            end
        end
        if (i_ctl.ctl4_wr) begin
            s_nxt.lock_info = i_ctl.info_region_lock;
        end
        // mode writes during an erase would fight the automatic clear
        if (i_ctl.mode_wr && !busy) begin
            s_nxt.mode = {i_ctl.multi_erase_select, i_ctl.erase_select};
        end
        // programming can only pull ones to zero
        if (i_prog_req && !busy) begin
            s_nxt.prog_word  = i_prog_old & i_prog_new;
            s_nxt.prog_valid = 1'b1;
        end
        unique case (s_r.st)
            ST_IDLE: begin
                if (start) begin
                    s_nxt.st    = ST_ERASE;
                    s_nxt.kind  = sel_kind;
                    s_nxt.tgt   = hit;
                    s_nxt.mask  = start_mask;
                    s_nxt.cnt   = ((sel_kind == EK_MASS) ? MASS_CYC : SEG_CYC) - 32'h1;
                    // bank and mass erase leave the CPU running elsewhere
                    s_nxt.stall = (sel_kind == EK_SEG) && i_exec_from_flash;
                end
            end
            ST_ERASE: begin
                if (s_r.cnt == 32'h0) begin
                    s_nxt.st    = ST_IDLE;
                    s_nxt.mode  = `FEC_MODE_NONE;
                    s_nxt.stall = 1'b0;
                    s_nxt.apply = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - 32'h1;
                end
            end
        endcase
        // set beats clear so a violation in the clearing cycle survives
        s_nxt.acc_viol = (s_r.acc_viol && !i_acc_viol_clr)
                       || (busy && (flash_wr || (flash_rd && conflict)));
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            s_r <= S_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------
    // outputs
    // ---------------------------------------------
    assign o_busy                  = busy;
    assign o_erase_mode            = s_r.mode;
    assign o_general_lock          = s_r.lock_gen;
    assign o_info_seg_a_lock       = s_r.lock_a;
    assign o_info_region_lock      = s_r.lock_info;
    assign o_access_violation_flag = s_r.acc_viol;
    assign o_cpu_stall             = s_r.stall;
    assign o_read_mode             = !busy;
    assign o_timing_gen_on         = busy;
    assign o_hv_gen_on             = busy;
    assign o_read_ok               = flash_rd && !conflict;
    assign o_write_ok              = flash_wr && !busy && (sel_kind == EK_NONE) && !wr_locked;
    assign o_erase_apply           = s_r.apply;
    assign o_erase_kind            = s_r.kind;
    assign o_erase_target          = s_r.tgt;
    assign o_erase_bank_mask       = s_r.mask[NUM_BANKS-1:0];
    assign o_prog_valid            = s_r.prog_valid;
    assign o_prog_word             = s_r.prog_word;

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    property p_start_busy;
        start |=> o_busy && o_timing_gen_on && !o_read_mode;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy not set after dummy write");

    property p_busy_hold;
        busy && s_r.cnt != 32'h0 |=> o_busy && (o_erase_mode == $past(o_erase_mode));
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped before timer end");

    property p_done_clear;
        busy && s_r.cnt == 32'h0 |=> !o_busy && o_erase_mode == 2'h0 && o_erase_apply ##1 !o_erase_apply;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("completion did not clear busy and mode");

    property p_lock_toggle;
        i_ctl.ctl3_wr && i_ctl.info_seg_a_lock |=> o_info_seg_a_lock != $past(o_info_seg_a_lock);
    endproperty
    a_lock_toggle: assert property (p_lock_toggle) else $error("segment A lock did not toggle");

    property p_lock_keep;
        !(i_ctl.ctl3_wr && i_ctl.info_seg_a_lock) |=> $stable(o_info_seg_a_lock);
    endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("segment A lock changed without a one");

    property p_info_locked;
        !busy && flash_wr && hit.region == RG_INFO && sel_kind == EK_SEG && s_r.lock_a |=> !o_busy;
    endproperty
    a_info_locked: assert property (p_info_locked) else $error("info segment erased while lock A set");

    property p_seg_a_write;
        is_seg_a && s_r.lock_a |-> !o_write_ok;
    endproperty
    a_seg_a_write: assert property (p_seg_a_write) else $error("segment A writable while locked");

    property p_gen_lock;
        !busy && flash_wr && s_r.lock_gen |=> !o_busy;
    endproperty
    a_gen_lock: assert property (p_gen_lock) else $error("erase started under general lock");

    property p_single_bank;
        NUM_BANKS == 1 && busy && flash_rd |-> !o_read_ok;
    endproperty
    a_single_bank: assert property (p_single_bank) else $error("read served during single-bank erase");

    property p_other_bank;
        busy && s_r.kind == EK_BANK && NUM_BANKS > 1 && flash_rd && hit.region == RG_MAIN
            && hit.bank != s_r.tgt.bank |-> o_read_ok;
    endproperty
    a_other_bank: assert property (p_other_bank) else $error("read of idle bank refused");

    property p_stall_flash;
        start && sel_kind == EK_SEG && i_exec_from_flash |=> o_cpu_stall throughout (o_busy [*2]);
    endproperty
    a_stall_flash: assert property (p_stall_flash) else $error("no stall for segment erase from flash");

    property p_no_stall;
        start && !i_exec_from_flash |=> !o_cpu_stall;
    endproperty
    a_no_stall: assert property (p_no_stall) else $error("stall for erase started from RAM");

    property p_violation;
        busy && flash_wr |=> o_access_violation_flag;
    endproperty
    a_violation: assert property (p_violation) else $error("new cycle while busy not flagged");

    property p_bank_mask;
        start |=> (o_erase_kind == EK_BANK) ? $onehot(o_erase_bank_mask)
                : (o_erase_kind == EK_MASS) ? (&o_erase_bank_mask) : (o_erase_bank_mask == '0);
    endproperty
    a_bank_mask: assert property (p_bank_mask) else $error("erase bank mask wrong for mode");

    property p_prog_bits;
        o_prog_valid |-> (o_prog_word & ~$past(i_prog_old)) == 16'h0;
    endproperty
    a_prog_bits: assert property (p_prog_bits) else $error("programming raised a bit");

    c_seg_erase:  cover property (start && sel_kind == EK_SEG ##[1:1000] o_erase_apply);
    c_bank_erase: cover property (start && sel_kind == EK_BANK ##[1:1000] o_erase_apply);
    c_mass_erase: cover property (start && sel_kind == EK_MASS ##[1:1000] o_erase_apply);
    c_violation:  cover property (busy && flash_wr ##1 o_access_violation_flag);
endmodule : flash_erase_controller

// ### dv/flash_cpu_model.sv
// behavioural cpu bus master facing the flash erase sequencer
`timescale 1ns/10ps
`include "flash_erase_cfg.svh"
module flash_cpu_model import flash_erase_pkg::*; (
    input  wire logic                   i_go,
    input  wire logic                   i_we,
    input  wire logic [`FEC_ADDR_W-1:0] i_addr,
    input  wire logic                   i_rude,
    input  wire logic                   i_busy,
    output bus_req_s                    o_bus
);
    // ---------------------------------------------
    // request gating
    // ---------------------------------------------
    // a polite master holds flash accesses back while busy; rude only when the bench asks
    always_comb begin
        o_bus.req  = i_go & (i_rude | ~i_busy);
        // released bus shows no stale value
        o_bus.we   = o_bus.req ? i_we : ~i_we;
        o_bus.addr = o_bus.req ? i_addr : ~i_addr;
    end
endmodule : flash_cpu_model

// ### dv/flash_erase_controller_tb.sv
// self-checking bench of the flash erase sequencer with a cpu model
`timescale 1ns/10ps
`include "flash_erase_cfg.svh"
module flash_erase_controller_tb import flash_erase_pkg::*;;
    logic clk = 1'b0, nrst = 1'b0, go = 1'b0, we = 1'b0, rude = 1'b0, exec_flash = 1'b0;
    logic viol_clr = 1'b0, prog_req = 1'b0;
    logic [15:0] prog_old = 16'h0000, prog_new = 16'h0000, pword;
    logic [19:0] addr = 20'h00000;
    ctl_wr_s ctl = '0;
    bus_req_s bus;
    logic busy, glock, alock, ilock, viol, stall, rmode, tgen, hvgen, rok, wok, apply, pvalid;
    logic [1:0] mode;
    logic [3:0] mask;
    erase_kind_e kind;
    region_info_s tgt;
    int n_errors = 0, checks_done = 0;

    always #20 clk = ~clk;

    flash_erase_controller #(.SEG_ERASE_US(1), .MASS_ERASE_US(2)) i_flash_erase_controller (
        .i_clk_sys(clk), .i_nrst(nrst), .i_bus(bus), .i_exec_from_flash(exec_flash), .i_ctl(ctl),
        .i_acc_viol_clr(viol_clr), .i_prog_req(prog_req), .i_prog_old(prog_old), .i_prog_new(prog_new),
        .o_busy(busy), .o_erase_mode(mode), .o_general_lock(glock), .o_info_seg_a_lock(alock),
        .o_info_region_lock(ilock), .o_access_violation_flag(viol), .o_cpu_stall(stall),
        .o_read_mode(rmode), .o_timing_gen_on(tgen), .o_hv_gen_on(hvgen), .o_read_ok(rok),
        .o_write_ok(wok), .o_erase_apply(apply), .o_erase_kind(kind), .o_erase_target(tgt),
        .o_erase_bank_mask(mask), .o_prog_valid(pvalid), .o_prog_word(pword));

    flash_cpu_model i_flash_cpu_model (.i_go(go), .i_we(we), .i_addr(addr), .i_rude(rude),
        .i_busy(busy), .o_bus(bus));

    // ---------------------------------------------
    // shared tasks
    // ---------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic wr_ctl(input logic [7:0] v);
        @(posedge clk) ctl <= v;
        @(posedge clk) ctl <= '0;
        #1;
    endtask : wr_ctl

    task automatic acc(input logic w, input logic [19:0] a, input logic r);
        @(posedge clk);
        go <= 1'b1;
        we <= w;
        addr <= a;
        rude <= r;
        #1;
    endtask : acc

    task automatic rel();
        @(posedge clk);
        go <= 1'b0;
        rude <= 1'b0;
        #1;
    endtask : rel

    task automatic start(input logic [7:0] m, input logic [19:0] a, input logic f, input logic [31:0] k,
                         input logic [31:0] bm, input logic st);
        wr_ctl(m);
        @(posedge clk);
        go <= 1'b1;
        we <= 1'b1;
        addr <= a;
        exec_flash <= f;
        rel();
        chk(busy, 1);
        chk(mode, m[6:5]);
        chk(kind, k);
        chk(mask, bm);
        chk(stall, st);
        chk(tgen & hvgen, 1);
    endtask : start

    // r further cycles of busy, then the completion cycle
    task automatic finish(input int r);
        repeat (r) begin
            @(posedge clk) #1;
            chk(busy, 1);
        end
        @(posedge clk) #1;
        chk(busy, 0);
        chk(mode, 0);
        chk(apply, 1);
        chk(stall, 0);
        chk(rmode, 1);
    endtask : finish

    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_reset();
        chk({busy, mode, viol, stall, tgen, hvgen, apply}, 0);
        chk({glock, alock, ilock, rmode}, 4'hF);
        wr_ctl(8'hA0);
        acc(1'b1, 20'h05000, 1'b0);
        rel();
        chk(busy, 0);
        $display("test reset and general lock done");
    endtask : t_reset

    task automatic t_locks();
        wr_ctl(8'h10);
        chk({glock, alock}, 2'h1);
        wr_ctl(8'h14);
        chk(alock, 0);
        wr_ctl(8'h14);
        chk(alock, 1);
        $display("test lock toggling done");
    endtask : t_locks

    task automatic t_seg_flash();
        start(8'hA0, 20'h05000, 1'b1, EK_SEG, 4'h0, 1'b1);
        acc(1'b1, 20'h05000, 1'b1);
        rel();
        @(posedge clk) viol_clr <= 1'b0;
        #1;
        chk(viol, 1);
        @(posedge clk) viol_clr <= 1'b1;
        @(posedge clk) viol_clr <= 1'b0;
        #1;
        chk(viol, 0);
        finish(19);
        $display("test segment erase from flash done");
    endtask : t_seg_flash

    task automatic t_bank_ram();
        start(8'hC0, 20'h25000, 1'b0, EK_BANK, 4'h4, 1'b0);
        acc(1'b0, 20'h05000, 1'b1);
        chk(rok, 1);
        acc(1'b0, 20'h25000, 1'b1);
        chk(rok, 0);
        rel();
        chk(viol, 1);
        finish(21);
        $display("test bank erase from ram done");
    endtask : t_bank_ram

    task automatic t_mass();
        start(8'hE0, 20'h05000, 1'b0, EK_MASS, 4'hF, 1'b0);
        acc(1'b0, 20'h01800, 1'b1);
        chk(rok, 1);
        rel();
        finish(47);
        $display("test mass erase done");
    endtask : t_mass

    task automatic t_info();
        wr_ctl(8'h02);
        wr_ctl(8'hA0);
        acc(1'b1, 20'h01880, 1'b0);
        rel();
        @(posedge clk) #1;
        chk(busy, 0);
        wr_ctl(8'hC0);
        acc(1'b1, 20'h01880, 1'b0);
        rel();
        @(posedge clk) #1;
        chk(busy, 0);
        wr_ctl(8'h14);
        start(8'hA0, 20'h01800, 1'b0, EK_SEG, 4'h0, 1'b0);
        chk({tgt.region, tgt.seg}, {RG_INFO, 8'h00});
        finish(24);
        start(8'hA0, 20'h01200, 1'b0, EK_SEG, 4'h0, 1'b0);
        chk({tgt.region, tgt.seg}, {RG_BOOT, 8'h01});
        finish(24);
        $display("test info and boot segments done");
    endtask : t_info

    task automatic t_prog();
        @(posedge clk);
        prog_req <= 1'b1;
        prog_old <= 16'hF0F0;
        prog_new <= 16'h3CFF;
        @(posedge clk) prog_req <= 1'b0;
        #1;
        chk(pvalid, 1);
        chk(pword, 16'h30F0);
        acc(1'b1, 20'h01800, 1'b0);
        chk(wok, 1);
        rel();
        wr_ctl(8'h14);
        acc(1'b1, 20'h01800, 1'b0);
        chk(wok, 0);
        rel();
        $display("test program merge done");
    endtask : t_prog

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        #1;
        t_reset();
        t_locks();
        t_seg_flash();
        t_bank_ram();
        t_mass();
        t_info();
        t_prog();
        test_done();
    end

    // hang guard
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule : flash_erase_controller_tb
